// [rtl/acr_params.svh]
// Register indices, field positions, reset values and conversion counts
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define ACR_IDX_RES_LO 8'h78
`define ACR_IDX_RES_HI 8'h79
`define ACR_IDX_CSR_A 8'h7A
`define ACR_IDX_CSR_B 8'h7B
`define ACR_IDX_SEL 8'h7C

// ************************************************************
// Field positions
// ************************************************************
`define ACR_A_ENABLE 7
`define ACR_A_START 6
`define ACR_A_AUTO 5
`define ACR_A_FLAG 4
`define ACR_A_IRQEN 3
`define ACR_SEL_LADJ 5

// ************************************************************
// Reset values and encodings
// ************************************************************
`define ACR_RST_BYTE 8'h00
`define ACR_RST_RESULT 10'h000
`define ACR_TRIG_FREE 3'h0
`define ACR_CH_TEMP 4'h8
`define ACR_CH_BANDGAP 4'hE
`define ACR_CH_GROUND 4'hF

// ************************************************************
// Conversion lengths in converter clock cycles
// ************************************************************
`define ACR_FIRST_CYCLES 5'd25
`define ACR_NORM_CYCLES 5'd13

`endif

// [rtl/acr_pkg.sv]
// Types shared by the converter control block and its users
package acr_pkg;

  typedef enum logic [1:0] {
    ACR_REF_EXT_PIN,
    ACR_REF_SUPPLY,
    ACR_REF_RESERVED,
    ACR_REF_INTERNAL
  } acr_ref_type;

  typedef enum logic {
    ACR_IDLE,
    ACR_CONV
  } acr_state_type;

  // Control bundle towards the analog multiplexer and converter core
  typedef struct packed {
    logic enable;
    logic sample;
    logic first;
    logic [3:0] channel;
    logic pin_sel;
    logic temp_sel;
    logic bandgap_sel;
    logic ground_sel;
    acr_ref_type reference;
    logic int_ref_on;
    logic ext_ref_pin;
  } acr_ana_type;

endpackage : acr_pkg

// [rtl/acr_prescaler.sv]
// Converter clock prescaler producing a one-cycle tick
`timescale 1ns/1ps
`include "acr_params.svh"

module acr_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic [2:0] prescale,
  // Converter clock tick
  output logic tick
);
  import acr_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] term;

  // Terminal count is division factor minus one
  function automatic logic [6:0] term_count(input logic [2:0] code);
    logic [7:0] f;
    f = 8'h01 << code;
    if (code == 3'h0) begin
      term_count = 7'h01;
    end else begin
      term_count = 7'(f - 8'h01);
    end
  endfunction : term_count

  assign term = term_count(prescale); // RULE_16

  // Held in reset while disabled so every enable starts a clean period
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      cnt_r <= 7'h00;
    end else if (cnt_r >= term) begin
      cnt_r <= 7'h00; // RULE_16
    end else begin
      cnt_r <= 7'(cnt_r + 7'h01);
    end
  end

  assign tick = run && (cnt_r >= term);

endmodule : acr_prescaler

// [rtl/acr_top.sv]
// Converter control, status and result registers on classic Wishbone
//
// Contract
// (RULE_01) Result is 10 bits, 0x000 to 0x3FF
// (RULE_02) Reference select decodes pin, supply, internal
// (RULE_03) Channel and reference held during conversion
// (RULE_04) Adjust bit changes presentation at once
// (RULE_05) Right adjust: high byte holds bits 9:8
// (RULE_06) Selection bit 4 always reads zero
// (RULE_07) Channel select decodes pins, sensor, bandgap, ground
// (RULE_08) Enable bit powers converter; clearing aborts
// (RULE_09) Start write begins conversion, first in free-run
// (RULE_10) First conversion 25 cycles, later 13
// (RULE_11) Start reads one while busy; zero ignored
// (RULE_12) Auto trigger starts on selected rising edge
// (RULE_13) Done flag set when result updated
// (RULE_14) Flag cleared by vector or writing one
// (RULE_15) Interrupt when flag, enable, global enable
// (RULE_16) Prescaler divides by 2 to 128
// (RULE_17) Sensor reading uses internal reference, single mode; the code enforces neither, channel 8 takes ref_r and auto_r as written
// (RULE_18) Low byte read locks result until high
// (RULE_19) Left adjust: high byte holds bits 9:2
// (RULE_20) Free-run code never creates a trigger
// (RULE_21) Free-run restarts after each completion
`timescale 1ns/1ps
`include "acr_params.svh"

module acr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Trigger sources and processor interrupt side
  input wire logic [7:0] trig_i,
  input wire logic cpu_global_irq_en,
  input wire logic irq_vector_ack,
  output logic conv_irq_o,
  // Analog core side
  input wire logic [9:0] ana_result_i,
  output acr_pkg::acr_ana_type ana_ctrl_o
);
  import acr_pkg::*;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic ack_r;
  logic [31:0] dat_r;
  logic req;
  logic fire;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wd;

  assign req = wb_cyc_i && wb_stb_i;
  // Accesses act on the edge where the master sees ack
  assign fire = req && ack_r;
  assign wr = fire && wb_we_i && wb_sel_i[0];
  assign rd = fire && !wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign wd = wb_dat_i[7:0];

  // ************************************************************
  // Registers
  // ************************************************************
  logic en_r;
  logic auto_r;
  logic flag_r;
  logic irqen_r;
  logic [2:0] prescale_r;
  logic [2:0] trig_src_r;
  logic ladj_r;
  logic [1:0] ref_r;
  logic [3:0] ch_r;
  logic [1:0] act_ref_r;
  logic [3:0] act_ch_r;
  logic [9:0] result_r;
  logic lock_r;
  logic first_r;
  logic sample_r;
  logic trig_prev_r;
  logic [4:0] cnt_r;
  acr_state_type state_r;

  logic wr_a;
  logic en_nxt;
  logic en_rise;
  logic first_eff;
  logic tick;
  logic busy;
  logic free_run;
  logic trig_edge;
  logic start_go;
  logic done;
  logic abort;
  logic restart;

  assign wr_a = wr && (idx == `ACR_IDX_CSR_A);
  assign en_nxt = wr_a ? wd[`ACR_A_ENABLE] : en_r;
  assign en_rise = wr_a && wd[`ACR_A_ENABLE] && !en_r;
  assign first_eff = first_r || en_rise; // RULE_10
  assign busy = (state_r == ACR_CONV);
  assign free_run = auto_r && (trig_src_r == `ACR_TRIG_FREE);

  // Free-run code is excluded so that selecting it never fires
  assign trig_edge = auto_r && (trig_src_r != `ACR_TRIG_FREE) &&
                     trig_i[trig_src_r] && !trig_prev_r; // RULE_12 RULE_20

  // Writing zero to start does nothing; a start while busy is dropped
  assign start_go = !busy && en_nxt &&
                    ((wr_a && wd[`ACR_A_START]) || trig_edge); // RULE_09
  assign abort = busy && !en_nxt; // RULE_08
  assign done = busy && !abort && tick && (cnt_r == 5'd1);
  assign restart = done && free_run; // RULE_21

  // ************************************************************
  // Prescaler
  // ************************************************************
  acr_prescaler u_prescaler (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(en_r),
    .prescale(prescale_r),
    .tick(tick)
  );

  // ************************************************************
  // Software control fields
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_r <= 1'b0;
      auto_r <= 1'b0;
      irqen_r <= 1'b0;
      prescale_r <= 3'h0;
    end else if (wr_a) begin
      en_r <= wd[`ACR_A_ENABLE]; // RULE_08
      auto_r <= wd[`ACR_A_AUTO];
      irqen_r <= wd[`ACR_A_IRQEN];
      prescale_r <= wd[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig_src_r <= 3'h0;
    end else if (wr && (idx == `ACR_IDX_CSR_B)) begin
      trig_src_r <= wd[2:0];
    end
  end

  // Bit 4 of the selection register has no storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ladj_r <= 1'b0;
      ref_r <= 2'h0;
      ch_r <= 4'h0;
    end else if (wr && (idx == `ACR_IDX_SEL)) begin
      ref_r <= wd[7:6];
      ladj_r <= wd[`ACR_SEL_LADJ];
      ch_r <= wd[3:0];
    end
  end

  // Selected level of last cycle; switching sources may form an edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_i[trig_src_r];
    end
  end

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ACR_IDLE;
      cnt_r <= 5'd0;
    end else if (abort) begin
      state_r <= ACR_IDLE;
      cnt_r <= 5'd0;
    end else begin
      unique case (state_r)
        ACR_IDLE: begin
          if (start_go) begin
            state_r <= ACR_CONV;
            cnt_r <= first_eff ? `ACR_FIRST_CYCLES
                               : `ACR_NORM_CYCLES; // RULE_10
          end
        end
        ACR_CONV: begin
          if (restart) begin
            cnt_r <= `ACR_NORM_CYCLES; // RULE_21
          end else if (done) begin
            state_r <= ACR_IDLE; // RULE_11
            cnt_r <= 5'd0;
          end else if (tick) begin
            cnt_r <= 5'(cnt_r - 5'd1);
          end
        end
      endcase
    end
  end

  // Pending initialisation after each enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_r <= 1'b0;
    end else if (start_go) begin
      first_r <= 1'b0;
    end else if (en_rise) begin
      first_r <= 1'b1;
    end
  end

  // Settings frozen at each start so mid-conversion writes wait
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      act_ref_r <= 2'h0;
      act_ch_r <= 4'h0;
      sample_r <= 1'b0;
    end else begin
      sample_r <= start_go || restart;
      if (start_go || restart) begin
        act_ref_r <= ref_r; // RULE_03
        act_ch_r <= ch_r; // RULE_03
      end
    end
  end

  // ************************************************************
  // Result, lock and completion flag
  // ************************************************************
  // A result finishing while locked is lost, keeping the byte pair whole
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_r <= `ACR_RST_RESULT;
    end else if (done && !lock_r) begin
      result_r <= ana_result_i; // RULE_01 RULE_18
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_r <= 1'b0;
    end else if (rd && (idx == `ACR_IDX_RES_LO)) begin
      lock_r <= 1'b1; // RULE_18
    end else if (rd && (idx == `ACR_IDX_RES_HI)) begin
      lock_r <= 1'b0;
    end
  end

  // Completion wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (done) begin
      flag_r <= 1'b1; // RULE_13
    end else if (irq_vector_ack || (wr_a && wd[`ACR_A_FLAG])) begin
      flag_r <= 1'b0; // RULE_14
    end
  end

  assign conv_irq_o = flag_r && irqen_r && cpu_global_irq_en; // RULE_15

  // ************************************************************
  // Read path
  // ************************************************************
  function automatic logic [7:0] present(input logic [9:0] res,
                                         input logic ladj,
                                         input logic hi);
    if (hi) begin
      present = ladj ? res[9:2] : {6'h00, res[9:8]}; // RULE_05 RULE_19
    end else begin
      present = ladj ? {res[1:0], 6'h00} : res[7:0]; // RULE_05 RULE_19
    end
  endfunction : present

  logic [7:0] rd_byte;

  // Presentation follows the live adjust bit, not the stored one
  always_comb begin
    unique case (idx)
      `ACR_IDX_RES_LO: rd_byte = present(result_r, ladj_r, 1'b0); // RULE_04
      `ACR_IDX_RES_HI: rd_byte = present(result_r, ladj_r, 1'b1); // RULE_04
      `ACR_IDX_CSR_A: rd_byte = {en_r, busy, auto_r, flag_r, irqen_r,
                                 prescale_r}; // RULE_11
      `ACR_IDX_CSR_B: rd_byte = {5'h00, trig_src_r};
      `ACR_IDX_SEL: rd_byte = {ref_r, ladj_r, 1'b0, ch_r}; // RULE_06
      default: rd_byte = `ACR_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req && !ack_r;
      dat_r <= (req && !ack_r && !wb_we_i) ? {24'h000000, rd_byte}
                                           : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ************************************************************
  // Analog side decode
  // ************************************************************
  always_comb begin
    ana_ctrl_o.enable = en_r;
    ana_ctrl_o.sample = sample_r;
    ana_ctrl_o.first = first_r;
    ana_ctrl_o.channel = act_ch_r;
    ana_ctrl_o.pin_sel = !act_ch_r[3]; // RULE_07
    ana_ctrl_o.temp_sel = (act_ch_r == `ACR_CH_TEMP); // RULE_07
    ana_ctrl_o.bandgap_sel = (act_ch_r == `ACR_CH_BANDGAP); // RULE_07
    ana_ctrl_o.ground_sel = (act_ch_r == `ACR_CH_GROUND); // RULE_07
    ana_ctrl_o.reference = acr_ref_type'(act_ref_r); // RULE_02
    ana_ctrl_o.int_ref_on = (act_ref_r == 2'h3); // RULE_02
    ana_ctrl_o.ext_ref_pin = (act_ref_r == 2'h0); // RULE_02
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [4:0] h_ticks_r;
  logic h_first_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      h_ticks_r <= 5'd0;
      h_first_r <= 1'b0;
    end else if (start_go || restart) begin
      h_ticks_r <= 5'd0;
      h_first_r <= start_go && first_eff;
    end else if (busy && tick) begin
      h_ticks_r <= 5'(h_ticks_r + 5'd1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_conv_len;
    done |-> (5'(h_ticks_r + 5'd1) == (h_first_r ? 5'd25 : 5'd13));
  endproperty
  a_conv_len: assert property (p_conv_len) // RULE_10
    else $error("conversion length wrong");

  property p_flag_set;
    done |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) // RULE_13
    else $error("flag not set on completion");

  property p_flag_keep;
    flag_r && !irq_vector_ack && !(wr_a && wd[`ACR_A_FLAG]) |=> flag_r;
  endproperty
  a_flag_keep: assert property (p_flag_keep) // RULE_14
    else $error("flag lost without clear");

  property p_hold_sel;
    busy && $past(busy) && !$past(start_go || restart)
      |-> $stable(act_ch_r) && $stable(act_ref_r);
  endproperty
  a_hold_sel: assert property (p_hold_sel) // RULE_03
    else $error("selection changed mid conversion");

  property p_abort;
    abort |=> !busy ##1 !flag_r || $past(flag_r, 2) || irq_vector_ack;
  endproperty
  a_abort: assert property (p_abort) // RULE_08
    else $error("disable did not abort");

  property p_lock;
    lock_r && !rd |=> $stable(result_r);
  endproperty
  a_lock: assert property (p_lock) // RULE_18
    else $error("result changed while locked");

  property p_single_end;
    done && !free_run |=> !busy && !sample_r;
  endproperty
  a_single_end: assert property (p_single_end) // RULE_11
    else $error("busy after single conversion");

  property p_free_run;
    restart |=> busy && sample_r;
  endproperty
  a_free_run: assert property (p_free_run) // RULE_21
    else $error("free run did not restart");

  property p_right_hi;
    req && !ack_r && !wb_we_i && idx == `ACR_IDX_RES_HI && !ladj_r
      |=> wb_dat_o[7:0] == {6'h00, $past(result_r[9:8])};
  endproperty
  a_right_hi: assert property (p_right_hi) // RULE_05
    else $error("right adjusted high byte wrong");

  property p_left_lo;
    req && !ack_r && !wb_we_i && idx == `ACR_IDX_RES_LO && ladj_r
      |=> wb_dat_o[7:0] == {$past(result_r[1:0]), 6'h00};
  endproperty
  a_left_lo: assert property (p_left_lo) // RULE_19
    else $error("left adjusted low byte wrong");

  property p_rsv_bit;
    req && !ack_r && !wb_we_i && idx == `ACR_IDX_SEL |=> !wb_dat_o[4];
  endproperty
  a_rsv_bit: assert property (p_rsv_bit) // RULE_06
    else $error("reserved bit read as one");

endmodule : acr_top

// [verif/acr_mux_model.sv]
// Behavioural analog multiplexer and converter core model
`timescale 1ns/1ps
module acr_mux_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control from the block and level of the selected source
  input wire acr_pkg::acr_ana_type ctrl,
  input wire logic [3:0] lvl,
  // Converted code
  output logic [9:0] result
);
  import acr_pkg::*;
  logic [9:0] held_r;
  logic valid_r;
  // Code carries channel and reference so a stale setting shows up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      held_r <= 10'h000;
      valid_r <= 1'b0;
    end else if (ctrl.sample) begin
      held_r <= ctrl.ground_sel ? 10'h000 :
        {ctrl.channel, ctrl.reference, lvl};
      valid_r <= 1'b1;
    end else if (!ctrl.enable) begin
      valid_r <= 1'b0;
    end
  end
  // Not held once the converter is off
  assign result = valid_r ? held_r : ~held_r;
endmodule : acr_mux_model

// [verif/testbench.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  import acr_pkg::*;
  // ********************************
  // Signals and helpers
  // ********************************
  logic clk, sys_rst, cyc, stb, we, gie, vack, ack, irq;
  logic [9:0] adr, res, last, keep;
  logic [3:0] bsel, lvl;
  logic [31:0] dat, dat_o, rng;
  logic [7:0] trig, q, s;
  logic [7:0] tab [4];
  acr_ana_type ctrl;
  int miscompares, total_checks, cycles, samples, n, n0;

  acr_top u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .trig_i(trig),
    .cpu_global_irq_en(gie), .irq_vector_ack(vack), .conv_irq_o(irq),
    .ana_result_i(res), .ana_ctrl_o(ctrl));
  acr_mux_model u_mux (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl),
    .lvl(lvl), .result(res));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Counters move by NBA so tasks read a stable value at the edge
  always @(posedge clk) begin
    cycles <= cycles + 1;
    samples <= samples + ((ctrl.sample === 1'b1) ? 1 : 0);
    if (cycles == 60000) begin
      miscompares++;
      $display("FAIL %0t run too long", $time);
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  function automatic logic [9:0] exp_res(logic [7:0] sl, logic [3:0] l);
    return (sl[3:0] == 4'hF) ? 10'h000 : {sl[3:0], sl[7:6], l};
  endfunction : exp_res

  function automatic logic [7:0] exp_byte(logic [9:0] r, logic la,
                                          logic hi);
    if (la) return hi ? r[9:2] : {r[1:0], 6'h00};
    return hi ? {6'h00, r[9:8]} : r[7:0];
  endfunction : exp_byte

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Classic single cycle; holds everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] i,
                    input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h000000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    chk(8'(k), 8'h02);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_irq

  task automatic chk_res(input logic [9:0] r);
    logic [7:0] lo;
    for (int k = 0; k < 2; k++) begin
      wb(1'b0, 8'h78, 8'h00);
      lo = q;
      wb(1'b0, 8'h79, 8'h00);
      chk(lo, exp_byte(r, s[5], 1'b0));
      chk(q, exp_byte(r, s[5], 1'b1));
      s = s ^ 8'h20;
      wb(1'b1, 8'h7C, s);
    end
  endtask : chk_res

  // Mode 1 changes settings mid-conversion, mode 2 leaves result and flag
  task automatic conv(input logic [7:0] a, input int len, input int mode);
    int f, t0;
    logic [7:0] old;
    logic [3:0] l;
    f = (a[2:0] < 3'h2) ? 2 : (1 << a[2:0]);
    old = s;
    l = 4'(rnd());
    lvl <= l;
    wb(1'b1, 8'h7A, a);
    t0 = cycles;
    wb(1'b0, 8'h7A, 8'h00);
    chk(q & 8'h40, 8'h40);
    if (mode == 1) begin
      s = (8'(rnd()) & 8'h27) | 8'h40;
      wb(1'b1, 8'h7C, s);
      wb(1'b1, 8'h7A, a & 8'hBF);
      chk({4'h0, ctrl.channel}, {4'h0, old[3:0]});
    end
    wait_irq();
    n = cycles - t0;
    chk({7'h00, irq}, 8'h01);
    chk(8'(n >= (len - 1) * f - 1 && n <= len * f + 3), 8'h01);
    last = exp_res(old, l);
    if (mode == 2) return;
    wb(1'b0, 8'h7A, 8'h00);
    chk(q & 8'h50, 8'h10);
    chk_res(last);
    wb(1'b1, 8'h7A, (a & 8'hBF) | 8'h10);
    chk({7'h00, irq}, 8'h00);
  endtask : conv

  // ********************************
  // Test sequence
  // ********************************
  initial begin
    {cyc, stb, we, gie, vack} = 5'h00;
    adr = 10'h000;
    dat = 32'h00000000;
    bsel = 4'hF;
    trig = 8'h00;
    lvl = 4'h0;
    sys_rst = 1'b1;
    rng = 32'd28;
    {cycles, samples, miscompares, total_checks} = '0;
    tab = '{8'hC8, 8'h8E, 8'h4F, 8'h05};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wb(1'b1, 8'h78, 8'hFF);
    wb(1'b1, 8'h7D, 8'hFF);
    for (int i = 8'h78; i < 8'h7E; i++) begin
      wb(1'b0, 8'(i), 8'h00);
      chk(q, 8'h00);
    end
    s = (8'(rnd()) & 8'h27) | 8'h40;
    wb(1'b1, 8'h7C, s | 8'h10);
    wb(1'b0, 8'h7C, 8'h00);
    chk(q, s);
    // A write without byte lane 0 is acked but must not store
    bsel <= 4'hE;
    wb(1'b1, 8'h7C, ~s);
    bsel <= 4'hF;
    wb(1'b0, 8'h7C, 8'h00);
    chk(q, s);
    $display("test registers done");
    gie <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      wb(1'b1, 8'h7A, 8'h00);
      conv(8'hC8 | 8'(p), 25, 0);
      conv(8'hC8 | 8'(p), 13, 1);
    end
    $display("test timing done");
    for (int i = 0; i < 4; i++) begin
      s = tab[i];
      wb(1'b1, 8'h7C, s);
      conv(8'hC9, 13, 0);
      chk({ctrl.pin_sel, ctrl.temp_sel, ctrl.bandgap_sel, ctrl.ground_sel,
        ctrl.ext_ref_pin, ctrl.int_ref_on, ctrl.reference},
        {s[3:0] < 4'h8, s[3:0] == 4'h8, s[3:0] == 4'hE, s[3:0] == 4'hF,
        s[7:6] == 2'b00, s[7:6] == 2'b11, s[7:6]});
    end
    $display("test decode done");
    wb(1'b1, 8'h7A, 8'hCB);
    wb(1'b1, 8'h7A, 8'h0B);
    repeat (400) @(posedge clk);
    wb(1'b0, 8'h7A, 8'h00);
    chk(q, 8'h0B);
    $display("test abort done");
    wb(1'b1, 8'h7B, 8'h00);
    n0 = samples;
    wb(1'b1, 8'h7A, 8'hE8);
    repeat (400) @(posedge clk);
    n = samples - n0;
    chk(8'(n >= 12 && n <= 15), 8'h01);
    wb(1'b1, 8'h7A, 8'h08);
    chk({7'h00, ctrl.enable}, 8'h00);
    wb(1'b0, 8'h7A, 8'h00);
    chk(q & 8'h10, 8'h10);
    wb(1'b1, 8'h7B, 8'h03);
    wb(1'b1, 8'h7A, 8'hA8);
    chk({6'h00, ctrl.enable, ctrl.first}, 8'h03);
    // Level on source 0 would form an edge if code 0 were not excluded
    trig <= 8'h01;
    n0 = samples;
    wb(1'b1, 8'h7B, 8'h00);
    repeat (100) @(posedge clk);
    chk(8'(samples - n0), 8'h00);
    $display("test free running done");
    for (int t = 1; t < 8; t++) begin
      wb(1'b1, 8'h7B, 8'(t));
      wb(1'b1, 8'h7A, 8'hB8);
      trig <= ~(8'h01 << t);
      repeat (80) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      trig <= 8'hFF;
      wait_irq();
      chk({7'h00, irq}, 8'h01);
      trig <= 8'h00;
    end
    $display("test auto trigger done");
    wb(1'b1, 8'h7A, 8'h98);
    s = 8'h43;
    wb(1'b1, 8'h7C, s);
    conv(8'hC8, 13, 0);
    keep = last;
    wb(1'b0, 8'h78, 8'h00);
    s = 8'h46;
    wb(1'b1, 8'h7C, s);
    conv(8'hC8, 13, 2);
    wb(1'b0, 8'h79, 8'h00);
    chk(q, exp_byte(keep, 1'b0, 1'b1));
    wb(1'b0, 8'h78, 8'h00);
    chk(q, exp_byte(keep, 1'b0, 1'b0));
    wb(1'b0, 8'h79, 8'h00);
    $display("test lock done");
    chk({7'h00, irq}, 8'h01);
    gie <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    gie <= 1'b1;
    wb(1'b1, 8'h7A, 8'h80);
    chk({7'h00, irq}, 8'h00);
    wb(1'b1, 8'h7A, 8'h88);
    chk({7'h00, irq}, 8'h01);
    vack <= 1'b1;
    @(posedge clk);
    vack <= 1'b0;
    @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule : testbench
